/* File: logic/sfsw_regs.svh */
// constants of the serial flash status write and read command logic
//
// How it works
// R1: status write accepted only if write_enable_latch was set earlier.
// R2: host lowers select_n, sends command byte then one data byte.
// R3: status write changes only bits 7, 3 and 2.
// R4: status bits 6, 5 and 4 always read zero.
// R5: select_n must rise right after data bit eight, else write discarded.
// R6: valid write starts timed cycle; write_in_progress high throughout, then low.
// R7: status register stays readable during the status write cycle.
// R8: end of status write cycle clears write_enable_latch.
// R9: write_protect_n low with status_write_disable set gives hardware_lock_mode.
// R10: hardware_lock_mode rejects every status write, latch or not.
// R11: with status_write_disable clear, only the latch gates a status write; code also refuses it while any write cycle runs.
// R12: in hardware_lock_mode protected area and status settings stay fixed; a status write already running when the pin falls still lands its new bits.
// R13: hardware_lock_mode entered whichever of bit or pin comes first.
// R14: hardware_lock_mode left only by write_protect_n going high; code also leaves it when a running status write lands bit 7 clear.
// R15: read: command, 24-bit address on rising edges, data on falling edges.
// R16: address increments per output byte and wraps to zero at the top.
// R17: select_n high ends a read, output released, back to idle.
// R18: read commands ignored while any write cycle runs.
// R19: fast read inserts one dummy byte after the address.
// R20: address bits above the device capacity are ignored.
// R21: latch clear refuses every write, program and erase command.
// R22: protect_size bits kept in non-volatile storage.
// R23: status bits: 7 disable, 3 and 2 protect size, 1 latch, 0 busy.
// R24: command bytes 0x01 status write, 0x03 read, 0x0b fast read.
`ifndef SFSW_REGS_SVH
`define SFSW_REGS_SVH

// ****************************************************************
// command bytes
// ****************************************************************
`define SFSW_CMD_WRSR  8'h01
`define SFSW_CMD_READ  8'h03
`define SFSW_CMD_FAST  8'h0b
`define SFSW_CMD_RDSR  8'h05
`define SFSW_CMD_WREN  8'h06
`define SFSW_CMD_WRDI  8'h04

// ****************************************************************
// status bit positions and reset values
// ****************************************************************
`define SFSW_BIT_SWD   7
`define SFSW_BIT_PSH   3
`define SFSW_BIT_PSL   2
`define SFSW_BIT_LATCH 1
`define SFSW_BIT_BUSY  0
`define SFSW_NV_RST    3'h0

// ****************************************************************
// pin indices into the synchroniser, idle levels
// ****************************************************************
`define SFSW_PIN_SEL   0
`define SFSW_PIN_SCK   1
`define SFSW_PIN_SI    2
`define SFSW_PIN_WP    3
`define SFSW_PIN_NUM   4
`define SFSW_PIN_RST   4'h9

// ****************************************************************
// timing
// ****************************************************************
`define SFSW_CLK_PERIOD_NS        25
`define SFSW_STATUS_WRITE_TIME_NS 15000000
`define SFSW_STATUS_WRITE_CYCLES  \
   ((`SFSW_STATUS_WRITE_TIME_NS + `SFSW_CLK_PERIOD_NS - 1) / `SFSW_CLK_PERIOD_NS)
`define SFSW_ADDR_W    18
`define SFSW_TMR_W     24

`endif

/* File: logic/sfsw_pkg.sv */
// types of the serial flash status write and read command logic
package sfsw_pkg;

   // command frame states
   typedef enum logic [2:0] {
      SFSW_IDLE,
      SFSW_CMD,
      SFSW_ADDR,
      SFSW_DUMMY,
      SFSW_OUT,
      SFSW_WSR,
      SFSW_HOLD,
      SFSW_SKIP
   } sfsw_state_t;

endpackage : sfsw_pkg

/* File: logic/sfsw_pin_if.sv */
// synchronised pin levels and edge pulses between synchroniser and core
`timescale 1ns/10ps
interface sfsw_pin_if #(
   parameter int W = 4
);
   logic [W-1:0] lvl;
   logic [W-1:0] rise;
   logic [W-1:0] fall;

   modport drv (output lvl, output rise, output fall);
   modport use_p (input lvl, input rise, input fall);
endinterface : sfsw_pin_if

/* File: logic/sfsw_pin_sync.sv */
// three-stage pin synchroniser with agreement filter and edge pulses
`timescale 1ns/10ps
module sfsw_pin_sync #(
   parameter int           W       = 4,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input  logic         mclk_i,
   input  logic         srst_i,
   input  logic         ce_i,
   input  logic [W-1:0] raw_i,
   sfsw_pin_if.drv      pins
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] lvl;
      logic [W-1:0] rise;
      logic [W-1:0] fall;
   } sfsw_sync_st_t;

   sfsw_sync_st_t q;
   sfsw_sync_st_t d;

   // ****************************************************************
   // next state: s1 feeds only s2; a change counts once s2 and s3 agree
   // ****************************************************************
   always_comb begin
      d      = q;
      d.s1   = raw_i;
      d.s2   = q.s1;
      d.s3   = q.s2;
      d.rise = '0;
      d.fall = '0;
      for (int i = 0; i < W; i++) begin
         if ((q.s2[i] == q.s3[i]) && (q.s3[i] != q.lvl[i])) begin
            d.lvl[i]  = q.s3[i];
            d.rise[i] = q.s3[i];
            d.fall[i] = ~q.s3[i];
         end
      end
   end

   // state register, frozen while the clock enable is low
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         q <= '{s1: RST_VAL, s2: RST_VAL, s3: RST_VAL, lvl: RST_VAL, rise: '0, fall: '0};
      end else if (ce_i) begin
         q <= d;
      end
   end

   assign pins.lvl  = q.lvl;
   assign pins.rise = q.rise;
   assign pins.fall = q.fall;

endmodule : sfsw_pin_sync

/* File: logic/sfsw_top.sv */
// serial flash command core: status write, protection modes, read commands
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/10ps
`include "sfsw_regs.svh"
module sfsw_top
   import sfsw_pkg::*;
#(
   parameter int ADDR_W              = `SFSW_ADDR_W,
   parameter int TMR_W               = `SFSW_TMR_W,
   parameter int STATUS_WRITE_CYCLES = `SFSW_STATUS_WRITE_CYCLES
) (
   input  logic              mclk_i,
   input  logic              srst_i,
   input  logic              ce_i,
   input  logic              select_n_i,
   input  logic              sclk_i,
   input  logic              serial_in_i,
   input  logic              write_protect_n_i,
   input  logic              other_cycle_busy_i,
   input  logic [2:0]        nv_status_i,
   input  logic [7:0]        mem_data_i,
   output logic              serial_out_o,
   output logic              serial_out_oe_o,
   output logic [ADDR_W-1:0] mem_addr_o,
   output logic              mem_rd_o,
   output logic              write_in_progress_o,
   output logic              write_enable_latch_o,
   output logic              hardware_lock_mode_o,
   output logic [1:0]        protect_size_o,
   output logic [2:0]        nv_status_o
);

   localparam logic [TMR_W-1:0] TMR_LOAD = TMR_W'(STATUS_WRITE_CYCLES - 1);

   typedef struct packed {
      sfsw_state_t       st;
      logic [4:0]        cnt;
      logic [7:0]        cmd;
      logic [7:0]        sh;
      logic [ADDR_W-1:0] addr;
      logic [7:0]        obyte;
      logic [2:0]        obit;
      logic [7:0]        nxt;
      logic              rd;
      logic              pend;
      logic              so;
      logic              oe;
      logic              swd;
      logic              psh;
      logic              psl;
      logic              wen;
      logic              busy;
      logic [2:0]        nst;
      logic [TMR_W-1:0]  tmr;
      logic              hwl;
      logic              booted;
   } sfsw_core_st_t;

   sfsw_core_st_t q;
   sfsw_core_st_t d;
   logic          bit_in;
   logic [7:0]    sh_next;
   logic [7:0]    byte_out;

   sfsw_pin_if #(.W(`SFSW_PIN_NUM)) pins ();

   // ****************************************************************
   // pin synchronisers
   // ****************************************************************
   sfsw_pin_sync #(
      .W       (`SFSW_PIN_NUM),
      .RST_VAL (`SFSW_PIN_RST)
   ) u_sfsw_pin_sync (
      .mclk_i (mclk_i),
      .srst_i (srst_i),
      .ce_i   (ce_i),
      .raw_i  ({write_protect_n_i, serial_in_i, sclk_i, select_n_i}),
      .pins   (pins)
   );

   // ****************************************************************
   // helpers
   // ****************************************************************
   // status byte as the host sees it; bits 6..4 are fixed zero
   function automatic logic [7:0] status_byte(input sfsw_core_st_t s);
      logic [7:0] b;
      b                = 8'h00;                     // R4
      b[`SFSW_BIT_SWD] = s.swd;                     // R23
      b[`SFSW_BIT_PSH] = s.psh;
      b[`SFSW_BIT_PSL] = s.psl;
      b[`SFSW_BIT_LATCH] = s.wen;
      b[`SFSW_BIT_BUSY]  = s.busy;
      return b;
   endfunction : status_byte

   // commands that move data out of the array
   function automatic logic is_read(input logic [7:0] c);
      return (c == `SFSW_CMD_READ) || (c == `SFSW_CMD_FAST);   // R24
   endfunction : is_read

   assign bit_in  = pins.lvl[`SFSW_PIN_SI];
   assign sh_next = {q.sh[6:0], bit_in};
   assign byte_out = (q.cmd == `SFSW_CMD_RDSR) ? status_byte(q) : q.nxt;

   // ****************************************************************
   // next state
   // ****************************************************************
   always_comb begin
      d      = q;
      d.rd   = 1'b0;
      d.pend = q.rd;

      // nonvolatile bits are taken once, the cycle after reset release
      if (!q.booted) begin
         d.booted               = 1'b1;
         {d.swd, d.psh, d.psl}  = nv_status_i;                        // R22
      end

      // lock decode is registered; pin low with bit set locks, pin high frees
      d.hwl = q.swd & ~pins.lvl[`SFSW_PIN_WP];                       // R9 R13 R14

      // array read data lands one cycle after the strobe, then step ahead
      if (q.pend) begin
         d.nxt  = mem_data_i;
         d.addr = q.addr + 1'b1;                                     // R16
      end

      // self-timed status write cycle; new bits and latch clear at the end
      if (q.busy) begin
         if (q.tmr == '0) begin
            d.busy                = 1'b0;                            // R6
            d.wen                 = 1'b0;                            // R8
            {d.swd, d.psh, d.psl} = q.nst;                           // R3
         end else begin
            d.tmr = q.tmr - 1'b1;
         end
      end

      if (pins.fall[`SFSW_PIN_SEL]) begin
         // a new frame always starts with the command byte
         d.st  = SFSW_CMD;
         d.cnt = 5'h0;
         d.oe  = 1'b0;
      end else if (pins.rise[`SFSW_PIN_SEL]) begin
         // deselect ends any frame and releases the output
         d.st = SFSW_IDLE;                                           // R17
         d.oe = 1'b0;                                                // R17
         if (q.st == SFSW_HOLD) begin
            case (q.cmd)
               `SFSW_CMD_WREN: begin
                  if (!q.busy) begin
                     d.wen = 1'b1;
                  end
               end
               `SFSW_CMD_WRDI: begin
                  if (!q.busy) begin
                     d.wen = 1'b0;
                  end
               end
               `SFSW_CMD_WRSR: begin
                  // only reached when exactly eight data bits came in
                  if (q.wen && !q.hwl && !q.busy && !other_cycle_busy_i) begin  // R1 R5 R10 R11 R12 R21
                     d.busy = 1'b1;                                  // R6
                     d.tmr = TMR_LOAD;
                     d.nst = {q.sh[`SFSW_BIT_SWD], q.sh[`SFSW_BIT_PSH],
                              q.sh[`SFSW_BIT_PSL]};                  // R3
                  end
               end
               default: begin
               end
            endcase
         end
      end else if (pins.rise[`SFSW_PIN_SCK] && !pins.lvl[`SFSW_PIN_SEL]) begin
         // input bits are taken on rising clock edges
         d.sh  = sh_next;
         d.cnt = q.cnt + 5'h1;
         case (q.st)
            SFSW_CMD: begin
               if (q.cnt == 5'd7) begin
                  d.cmd = sh_next;
                  d.cnt = 5'h0;
                  case (sh_next)
                     `SFSW_CMD_READ, `SFSW_CMD_FAST: begin
                        // a running cycle is left alone, the read dropped
                        d.st = (q.busy || other_cycle_busy_i) ? SFSW_SKIP : SFSW_ADDR;  // R18
                     end
                     `SFSW_CMD_RDSR: begin
                        d.st   = SFSW_OUT;                           // R7
                        d.obit = 3'h0;
                     end
                     `SFSW_CMD_WRSR: begin
                        d.st = SFSW_WSR;                             // R2
                     end
                     `SFSW_CMD_WREN, `SFSW_CMD_WRDI: begin
                        d.st = SFSW_HOLD;
                     end
                     default: begin
                        d.st = SFSW_SKIP;
                     end
                  endcase
               end
            end
            SFSW_ADDR: begin
               // only the low bits are kept, so upper bits fall off
               d.addr = {q.addr[ADDR_W-2:0], bit_in};                // R20
               if (q.cnt == 5'd23) begin                             // R15
                  d.cnt = 5'h0;
                  if (q.cmd == `SFSW_CMD_FAST) begin
                     d.st = SFSW_DUMMY;                              // R19
                  end else begin
                     d.st   = SFSW_OUT;
                     d.obit = 3'h0;
                     d.rd   = 1'b1;
                  end
               end
            end
            SFSW_DUMMY: begin
               if (q.cnt == 5'd7) begin                              // R19
                  d.cnt  = 5'h0;
                  d.st   = SFSW_OUT;
                  d.obit = 3'h0;
                  d.rd   = 1'b1;
               end
            end
            SFSW_WSR: begin
               if (q.cnt == 5'd7) begin
                  d.cnt = 5'h0;
                  d.st  = SFSW_HOLD;
               end
            end
            SFSW_HOLD: begin
               // a ninth bit spoils the frame; deselect will find nothing to do
               d.st = SFSW_SKIP;                                     // R5
            end
            default: begin
            end
         endcase
      end else if (pins.fall[`SFSW_PIN_SCK] && !pins.lvl[`SFSW_PIN_SEL] &&
                   (q.st == SFSW_OUT)) begin
         // output bits change on falling clock edges, msb first
         d.oe   = 1'b1;
         d.obit = q.obit + 3'h1;
         if (q.obit == 3'h0) begin
            d.so    = byte_out[7];                                   // R15
            d.obyte = {byte_out[6:0], 1'b0};
            d.rd    = is_read(q.cmd);                                // R16
         end else begin
            d.so    = q.obyte[7];
            d.obyte = {q.obyte[6:0], 1'b0};
         end
      end
   end

   // ****************************************************************
   // state register
   // ****************************************************************
   // one register for all state keeps the clock enable freeze uniform
   always_ff @(posedge mclk_i) begin
      if (srst_i) begin
         q        <= '0;
         q.st     <= SFSW_IDLE;
         {q.swd, q.psh, q.psl} <= `SFSW_NV_RST;
      end else if (ce_i) begin
         q <= d;
      end
   end

   // ****************************************************************
   // outputs, all straight from the state register
   // ****************************************************************
   assign serial_out_o         = q.so;
   assign serial_out_oe_o      = q.oe;
   assign mem_addr_o           = q.addr;
   assign mem_rd_o             = q.rd;
   assign write_in_progress_o  = q.busy;
   assign write_enable_latch_o = q.wen;
   assign hardware_lock_mode_o = q.hwl;                              // R12
   assign protect_size_o       = {q.psh, q.psl};
   assign nv_status_o          = {q.swd, q.psh, q.psl};              // R22

endmodule : sfsw_top

/* File: verification/sfsw_checker.sv */
// port assertions of the serial flash command core
`timescale 1ns/10ps
module sfsw_checker #(
   parameter int ADDR_W              = 18,
   parameter int STATUS_WRITE_CYCLES = 20
) (
   input logic              mclk_i,
   input logic              srst_i,
   input logic              select_n_i,
   input logic              write_protect_n_i,
   input logic              other_cycle_busy_i,
   input logic              serial_out_oe_o,
   input logic [ADDR_W-1:0] mem_addr_o,
   input logic              mem_rd_o,
   input logic              write_in_progress_o,
   input logic              write_enable_latch_o,
   input logic              hardware_lock_mode_o,
   input logic [2:0]        nv_status_o
);
   logic [31:0] busy_cnt_q;

   // length of the running busy stretch, judged at its fall
   always_ff @(posedge mclk_i) begin
      if (srst_i || !write_in_progress_o) busy_cnt_q <= '0;
      else busy_cnt_q <= busy_cnt_q + 32'h1;
   end

   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (srst_i);

   // ****************************************************************
   // status write cycle
   // ****************************************************************
   property p_busy_len;
      $fell(write_in_progress_o) |-> busy_cnt_q == STATUS_WRITE_CYCLES && !write_enable_latch_o;
   endproperty
   a_busy_len: assert property (p_busy_len) else $error("busy length or latch");
   property p_wel_start;
      $rose(write_in_progress_o) |-> write_enable_latch_o;
   endproperty
   a_wel_start: assert property (p_wel_start) else $error("write without latch");

   // ****************************************************************
   // lock modes and reads
   // ****************************************************************
   // a write already running when the pin falls would break this
   property p_lock_hold;
      hardware_lock_mode_o |=> $stable(nv_status_o);
   endproperty
   a_lock_hold: assert property (p_lock_hold) else $error("status changed in lock");
   property p_lock_rise;
      $rose(hardware_lock_mode_o) |-> nv_status_o[2] && !write_protect_n_i;
   endproperty
   a_lock_rise: assert property (p_lock_rise) else $error("lock without cause");
   property p_lock_fall;
      $fell(hardware_lock_mode_o) |-> write_protect_n_i;
   endproperty
   a_lock_fall: assert property (p_lock_fall) else $error("lock left, pin low");
   // data lands the cycle after the strobe, the address steps the cycle after that
   property p_addr;
      mem_rd_o |-> ##2 mem_addr_o == ADDR_W'($past(mem_addr_o, 2) + 1);
   endproperty
   a_addr: assert property (p_addr) else $error("address not stepped");
   property p_rd_busy;
      mem_rd_o |-> !write_in_progress_o && !other_cycle_busy_i;
   endproperty
   a_rd_busy: assert property (p_rd_busy) else $error("array read while busy");
   property p_oe_drop;
      $rose(select_n_i) |-> ##[1:8] !serial_out_oe_o;
   endproperty
   a_oe_drop: assert property (p_oe_drop) else $error("output kept after deselect");
endmodule : sfsw_checker

bind sfsw_top sfsw_checker #(
   .ADDR_W              (ADDR_W),
   .STATUS_WRITE_CYCLES (STATUS_WRITE_CYCLES)
) u_sfsw_checker (.*);

/* File: verification/sfsw_spi_host.sv */
// spi host model driving select, clock and data of the flash core
`timescale 1ns/10ps
module sfsw_spi_host (
   input  logic       mclk_i,
   input  logic       so_i,
   output logic       select_n_o,
   output logic       sclk_o,
   output logic       si_o,
   output logic [7:0] rx_o,
   output logic       rx_stb_o
);
   // idle: deselected, clock parked low between frames
   initial begin
      select_n_o = 1'b1;
      sclk_o     = 1'b0;
      si_o       = 1'b0;
      rx_o       = 8'h00;
      rx_stb_o   = 1'b0;
   end
   task automatic wt(input int n);
      repeat (n) @(posedge mclk_i);
   endtask : wt
   task automatic sel();
      select_n_o <= 1'b0;
      wt(4);
   endtask : sel
   // data set while clock low, latched at the rise; 8 cycles per bit
   task automatic bit_x(input logic b, output logic r);
      sclk_o <= 1'b0;
      si_o   <= b;
      wt(4);
      sclk_o <= 1'b1;
      wt(4);
      r = so_i;
   endtask : bit_x
   // msb first; chk hands the byte to the bench monitor
   task automatic xfer(input logic [7:0] tx, input logic chk, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) bit_x(tx[i], rx[i]);
      if (chk) begin
         rx_o     <= rx;
         rx_stb_o <= 1'b1;
         wt(1);
         rx_stb_o <= 1'b0;
      end
   endtask : xfer
   // clock back low before deselect; the released data line flips
   task automatic fin();
      sclk_o <= 1'b0;
      wt(4);
      select_n_o <= 1'b1;
      si_o       <= ~si_o;
      wt(16);
   endtask : fin
endmodule : sfsw_spi_host

/* File: verification/tb_top.sv */
// self-checking bench of the serial flash command core
`timescale 1ns/10ps
`include "sfsw_regs.svh"
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_mismatch++; \
   $display("Error at %0t: got %h want %h", $time, a, b); end end
module tb_top;
   localparam int SWC = 1000; // short busy cycle keeps the run small
   logic mclk_i, srst_i, ce_i, select_n_i, sclk_i, serial_in_i, write_protect_n_i;
   logic other_cycle_busy_i, serial_out_o, serial_out_oe_o, mem_rd_o;
   logic write_in_progress_o, write_enable_latch_o, hardware_lock_mode_o;
   logic [2:0] nv_status_i, nv_status_o, nv;
   logic [7:0] mem_data_i, rx, r, exp_b;
   logic [1:0] protect_size_o;
   logic [17:0] mem_addr_o;
   logic rx_stb, b;
   logic [7:0] exp_q[$];
   int n_mismatch, checks_done, seed;

   sfsw_top #(.STATUS_WRITE_CYCLES(SWC)) u_sfsw_top (.*);
   sfsw_spi_host u_sfsw_spi_host (
      .mclk_i     (mclk_i),
      .so_i       (serial_out_oe_o ? serial_out_o : ~serial_out_o), // released line flips
      .select_n_o (select_n_i),
      .sclk_o     (sclk_i),
      .si_o       (serial_in_i),
      .rx_o       (rx),
      .rx_stb_o   (rx_stb)
   );
   function automatic logic [7:0] pat(input logic [17:0] a);
      return a[7:0] ^ a[17:10];
   endfunction : pat
   // array model: byte of the strobed address lands the next cycle
   always @(posedge mclk_i) mem_data_i <= pat(mem_addr_o);
   // monitor: every byte the host hands back meets the oldest note
   always @(posedge mclk_i) begin
      if (rx_stb === 1'b1) begin
         // pop once, the compare macro reads its arguments twice
         exp_b = exp_q.pop_front();
         `CHK(rx, exp_b)
      end
   end
   initial begin
      mclk_i = 1'b0;
      forever #12.5 mclk_i = ~mclk_i;
   end
   task automatic summarize();
      $display("mismatches %0d checks %0d", n_mismatch, checks_done);
      if (n_mismatch == 0 && checks_done > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : summarize
   task automatic wt(input int n);
      repeat (n) @(posedge mclk_i);
   endtask : wt
   task automatic cmd(input logic [7:0] c);
      u_sfsw_spi_host.sel();
      u_sfsw_spi_host.xfer(c, 1'b0, r);
   endtask : cmd
   task automatic wrsr(input logic [7:0] d, input logic en);
      if (en) begin
         cmd(`SFSW_CMD_WREN);
         u_sfsw_spi_host.fin();
      end
      cmd(`SFSW_CMD_WRSR);
      u_sfsw_spi_host.xfer(d, 1'b0, r);
      u_sfsw_spi_host.fin();
   endtask : wrsr
   task automatic rdsr(input logic [7:0] e);
      cmd(`SFSW_CMD_RDSR);
      exp_q.push_back(e);
      u_sfsw_spi_host.xfer(8'h00, 1'b1, r);
      u_sfsw_spi_host.fin();
   endtask : rdsr
   task automatic wait_idle();
      int k;
      k = 0;
      while (write_in_progress_o !== 1'b0 && k < 3000) begin
         wt(1);
         k++;
      end
      if (k >= 3000) begin
         n_mismatch++;
         $display("Error at %0t: busy never ended", $time);
         summarize();
      end
   endtask : wait_idle
   // ok low: a refused read must leave the output released
   task automatic rd(input logic f, input logic [23:0] a, input int n, input logic ok);
      logic [17:0] p;
      p = a[17:0];
      cmd(f ? `SFSW_CMD_FAST : `SFSW_CMD_READ);
      for (int i = 2; i >= 0; i--) u_sfsw_spi_host.xfer(a[8*i+:8], 1'b0, r);
      if (f) u_sfsw_spi_host.xfer(8'($urandom), 1'b0, r);
      for (int i = 0; i < n; i++) begin
         if (ok) exp_q.push_back(pat(p));
         p = p + 18'h1;
         u_sfsw_spi_host.xfer(8'($urandom), ok, r);
      end
      `CHK(serial_out_oe_o, ok)
      u_sfsw_spi_host.fin();
      `CHK(serial_out_oe_o, 1'b0)
   endtask : rd
   // main sequence
   initial begin
      seed = $urandom(34281);
      nv = 3'($urandom);
      {srst_i, ce_i, write_protect_n_i, other_cycle_busy_i} = 4'he;
      nv_status_i = nv;
      n_mismatch = 0;
      checks_done = 0;
      wt(16);
      srst_i <= 1'b0;
      wt(4);
      `CHK(nv_status_o, nv)
      rdsr({nv[2], 3'h0, nv[1:0], 2'h0});
      wrsr(8'h0c, 1'b0);
      wt(10);
      `CHK(write_in_progress_o, 1'b0)
      cmd(`SFSW_CMD_WREN);
      u_sfsw_spi_host.fin();
      cmd(`SFSW_CMD_WRSR);
      u_sfsw_spi_host.xfer(8'h0c, 1'b0, r);
      u_sfsw_spi_host.bit_x(1'b0, b);
      u_sfsw_spi_host.fin();
      wt(10);
      `CHK(write_in_progress_o, 1'b0)
      wrsr(8'hff, 1'b1);
      rdsr({nv[2], 3'h0, nv[1:0], 2'h3});
      rd(1'b0, 24'h000100, 2, 1'b0);
      wait_idle();
      rdsr(8'h8c);
      `CHK(protect_size_o, 2'h3)
      write_protect_n_i <= 1'b0;
      wt(10);
      `CHK(hardware_lock_mode_o, 1'b1)
      wrsr(8'h00, 1'b1);
      wt(10);
      `CHK(write_in_progress_o, 1'b0)
      rdsr(8'h8e);
      write_protect_n_i <= 1'b1;
      wt(10);
      `CHK(hardware_lock_mode_o, 1'b0)
      wrsr(8'h00, 1'b1);
      wait_idle();
      write_protect_n_i <= 1'b0;
      wt(10);
      wrsr(8'h84, 1'b1);
      wait_idle();
      wt(4);
      `CHK(hardware_lock_mode_o, 1'b1)
      rdsr(8'h84);
      write_protect_n_i <= 1'b1;
      wt(10);
      other_cycle_busy_i <= 1'b1;
      rd(1'b1, 24'h000010, 1, 1'b0);
      other_cycle_busy_i <= 1'b0;
      rd(1'b0, {6'($urandom), 18'h3fffd}, 5, 1'b1);
      rd(1'b1, 24'($urandom), 3, 1'b1);
      wt(4);
      `CHK(exp_q.size(), 0)
      summarize();
   end
endmodule : tb_top
